// >>> rtl/ipp_defs.vh
// constants for the interrupt priority and posting block
`ifndef IPP_DEFS_VH
`define IPP_DEFS_VH
`define IPP_VEC_W 8
`define IPP_PRI_W 5
`define IPP_PRI_SHIFT 3
`define IPP_PRI_MAX 5'h1F
`define IPP_NMI_VECTOR 8'hF8
`define IPP_VEC_MIN 8'h08
`define IPP_RSV_LO_A 8'hF4
`define IPP_RSV_HI_A 8'hF7
`define IPP_RSV_LO_B 8'hF9
`define IPP_RSV_HI_B 8'hFB
`define IPP_TABLE_BYTES 32'h00000404
`define IPP_PEND_PRI_OFS 32'h00000000
`define IPP_PEND_VEC_OFS 32'h00000004
`define IPP_VEC_ENTRY_OFS 32'h00000024
`define IPP_REC_AC_OFS 32'h0000000C
`define IPP_REC_PC_OFS 32'h00000010
`define IPP_REC_VEC_OFS 32'h00000008
`define IPP_FRAME_BYTES 32'h00000040
`define IPP_RET_INTERRUPT 3'h7
`define IPP_PC_PRI_LSB 16
`define IPP_PC_TRACE_BIT 0
`define IPP_PC_MODE_BIT 1
`define IPP_PC_STATE_BIT 13
`define IPP_SRC_EXT 2'h0
`define IPP_SRC_TIMER 2'h1
`define IPP_SRC_SW 2'h2
`endif

// >>> rtl/ipp_interrupt_priority_posting.v
// interrupt priority resolution, posting and dispatch engine
//
// Summary of operation
// - priority of a request is its vector number divided by eight
// - vectors zero to seven are never raised and are not handled
// - service at once only if request priority exceeds current priority, or both are 31
// - otherwise the request is posted pending for later service, or dropped in a cycle with initLoad high
// - among pending requests of one level the largest vector goes first
// - a priority 31 request preempts even at current priority 31
// - a priority zero request never preempts anything
// - the nonmaskable input dispatches through vector 248
// - sources use vectors 8-243 and 252-255; reserved vectors never raised
// - vector entries are words; handler address low two bits forced zero
// - first 36 table bytes hold pending priority and vector bitmaps
// - posting sets the pending priority bit of the request level
// - 256 bit pending vector bitmap, one bit per vector, byte 4 reserved
// - posting also sets the vector bit in the pending vector bitmap
// - pending search tests priority bitmap first, then vector bitmap
// - record holds vector, saved controls at frame minus 12 and minus 16
// - interrupt stack grows upward like the local stack
// - interrupt call switches stack, makes frame, saves interrupted state
// - return restores state and switches back to previous stack
// - sources are external port, nonmaskable input, timers, software
// - at initialisation keep table pointer and interrupt stack base
// - servicing sets priority, supervisor mode, clears trace, status 111
`timescale 1ns/1ps
`include "ipp_defs.vh"

module ipp_interrupt_priority_posting #(
    parameter VEC_W = 8,
    parameter ADDR_W = 32
) (
    input wire sysClk,                  // processor clock
    input wire reset,                   // synchronous reset, high
    input wire clkEn,                   // freezes all state when low
    input wire initLoad,                // pulse: capture table and stack pointers
    input wire [ADDR_W-1:0] initTablePtr, // table byte 0 address
    input wire [ADDR_W-1:0] initStackBase, // interrupt stack base
    input wire [7:0] extReqPin,         // external request port, async
    input wire [VEC_W-1:0] extVector,   // vector for external requests
    input wire nmiPinN,                 // nonmaskable input, async, active low
    input wire timerReq,                // timer request pulse
    input wire [VEC_W-1:0] timerVector, // timer vector
    input wire swReq,                   // software request pulse
    input wire [VEC_W-1:0] swVector,    // software vector
    input wire [31:0] curAc,            // live arithmetic controls
    input wire [31:0] curPc,            // live process controls
    input wire [ADDR_W-1:0] curFp,      // live frame pointer
    input wire retReq,                  // pulse: return from handler
    input wire [31:0] savedAc,          // record arithmetic controls
    input wire [31:0] savedPc,          // record process controls
    output reg [ADDR_W-1:0] tablePtr,   // kept table pointer
    output reg [ADDR_W-1:0] stackBase,  // kept interrupt stack base
    output reg [4:0] curPriority,       // current execution priority
    output reg inInterrupt,             // interrupted state
    output reg supervisorMode,          // supervisor mode
    output reg traceEnable,             // trace enable
    output reg [31:0] pendPri,          // pending priority bitmap
    output reg [255:0] pendVec,         // pending vector bitmap
    output reg callValid,               // pulse: interrupt call made
    output reg [VEC_W-1:0] callVector,  // serviced vector
    output reg [ADDR_W-1:0] entryAddr,  // vector entry byte address
    output reg [ADDR_W-1:0] newFramePointer, // new frame on interrupt stack
    output reg [ADDR_W-1:0] recAcAddr,  // where saved controls go
    output reg [ADDR_W-1:0] recPcAddr,  // where saved process controls go
    output reg [ADDR_W-1:0] recVecAddr, // where vector number goes
    output reg [31:0] recAc,            // arithmetic controls to save
    output reg [31:0] recPc,            // process controls to save
    output reg [2:0] returnStatus,      // frame return status
    output reg [ADDR_W-1:0] previousFrameLink, // frame to resume
    output reg retValid,                // pulse: return complete
    input wire [31:0] handlerWord,      // vector entry read from memory
    output wire [ADDR_W-1:0] handlerAddr // branch target, word aligned
);

    // ****************************************
    // request synchronisers and source select
    // ****************************************
    reg [7:0] extS1;
    reg [7:0] extS2;
    reg [7:0] extS3;
    reg nmiS1;
    reg nmiS2;
    reg nmiS3;
    reg [7:0] extStable;
    reg nmiStable;
    reg nmiPrev;
    reg [7:0] extPrevMask;

    // edge detectors idle low after reset, so no false edge
    wire [7:0] extRise = extStable & ~extPrevMask;

    always @(posedge sysClk) begin
        if (reset) begin
            extS1 <= 8'h00;
            extS2 <= 8'h00;
            extS3 <= 8'h00;
            nmiS1 <= 1'b0;
            nmiS2 <= 1'b0;
            nmiS3 <= 1'b0;
            extStable <= 8'h00;
            nmiStable <= 1'b0;
            nmiPrev <= 1'b0;
            extPrevMask <= 8'h00;
        end else if (clkEn) begin
            extS1 <= extReqPin;
            extS2 <= extS1;
            extS3 <= extS2;
            nmiS1 <= ~nmiPinN;
            nmiS2 <= nmiS1;
            nmiS3 <= nmiS2;
            if (extS2 == extS3) begin
                extStable <= extS2;
            end
            if (nmiS2 == nmiS3) begin
                nmiStable <= nmiS2;
            end
            nmiPrev <= nmiStable;
            extPrevMask <= extStable;
        end
    end

    wire nmiEdge = nmiStable & ~nmiPrev;
    wire extEdge = |extRise;

    reg reqValid;
    reg [VEC_W-1:0] reqVec;
    always @* begin
        reqValid = 1'b0;
        reqVec = {VEC_W{1'b0}};
        if (nmiEdge) begin
            reqValid = 1'b1;
            reqVec = `IPP_NMI_VECTOR;
        end else if (extEdge) begin
            reqValid = 1'b1;
            reqVec = extVector;
        end else if (timerReq) begin
            reqValid = 1'b1;
            reqVec = timerVector;
        end else if (swReq) begin
            reqValid = 1'b1;
            reqVec = swVector;
        end
    end

    // ****************************************
    // request checks
    // ****************************************
    // reserved vectors never raised; dropped if seen
    wire reqReserved = ((reqVec >= `IPP_RSV_LO_A) && (reqVec <= `IPP_RSV_HI_A)) ||
        ((reqVec >= `IPP_RSV_LO_B) && (reqVec <= `IPP_RSV_HI_B));
    wire reqUsable = reqValid && (reqVec >= `IPP_VEC_MIN) && !reqReserved;
    wire [4:0] reqPri = reqVec[7:`IPP_PRI_SHIFT];

    function preempts;
        input [4:0] p;
        input [4:0] cur;
        begin
            preempts = (p != 5'h00) &&
                ((p > cur) || (p == `IPP_PRI_MAX && cur == `IPP_PRI_MAX));
        end
    endfunction

    // ****************************************
    // pending search
    // ****************************************
    // pending bitmap layout
    localparam PEND_PRI_BITS = 32;
    localparam PEND_VEC_BITS = 256;
    localparam LEVEL_VECS = 8;

    reg [4:0] topPri;
    reg topAny;
    integer i;
    always @* begin
        topPri = 5'h00;
        topAny = 1'b0;
        for (i = 0; i < PEND_PRI_BITS; i = i + 1) begin
            if (pendPri[i]) begin
                topPri = i[4:0];
                topAny = 1'b1;
            end
        end
    end

    wire [7:0] levelBits = pendVec[{topPri, 3'h0} +: 8];
    reg [2:0] topLow;
    integer j;
    always @* begin
        topLow = 3'h0;
        for (j = 0; j < LEVEL_VECS; j = j + 1) begin
            if (levelBits[j]) begin
                topLow = j[2:0];
            end
        end
    end
    wire [7:0] pendTopVec = {topPri, topLow};
    wire pendReady = topAny && preempts(topPri, curPriority);

    // one-hot of the highest vector left in the level
    wire [7:0] levelTop;
    genvar g;
    generate
        for (g = 0; g < LEVEL_VECS; g = g + 1) begin : gLevelTop
            if (g == LEVEL_VECS - 1) begin : gLast
                assign levelTop[g] = levelBits[g];
            end else begin : gRest
                assign levelTop[g] = levelBits[g] & ~(|levelBits[LEVEL_VECS-1:g+1]);
            end
        end
    endgenerate
    wire [7:0] levelRest = levelBits & ~levelTop;
    wire levelEmpties = (levelRest == 8'h00);

    // ****************************************
    // service, post and return
    // ****************************************
    wire reqNow = reqUsable && preempts(reqPri, curPriority);
    wire pendOnly = pendReady && !reqNow;
    wire doService = reqNow || pendOnly;
    wire [7:0] svcVec = reqNow ? reqVec : pendTopVec;
    wire svcFromPend = pendOnly;

    assign handlerAddr = {handlerWord[ADDR_W-1:2], 2'b00};

    // ****************************************
    // interrupt stack bookkeeping
    // ****************************************
    reg [ADDR_W-1:0] stackTop;
    reg [ADDR_W-1:0] fpStack [0:31];
    reg [4:0] depth;
    wire depthFull = (depth == 5'h1F);

    wire [ADDR_W-1:0] frameBase = inInterrupt ? stackTop : stackBase;
    wire [ADDR_W-1:0] nextFrame = frameBase + `IPP_FRAME_BYTES;

    // ****************************************
    // handler state and pending bitmaps
    // ****************************************
    always @(posedge sysClk) begin
        if (reset) begin
            tablePtr <= {ADDR_W{1'b0}};
            stackBase <= {ADDR_W{1'b0}};
            stackTop <= {ADDR_W{1'b0}};
            curPriority <= 5'h00;
            inInterrupt <= 1'b0;
            supervisorMode <= 1'b0;
            traceEnable <= 1'b0;
            pendPri <= 32'h00000000;
            pendVec <= {PEND_VEC_BITS{1'b0}};
            callValid <= 1'b0;
            callVector <= {VEC_W{1'b0}};
            entryAddr <= {ADDR_W{1'b0}};
            newFramePointer <= {ADDR_W{1'b0}};
            recAcAddr <= {ADDR_W{1'b0}};
            recPcAddr <= {ADDR_W{1'b0}};
            recVecAddr <= {ADDR_W{1'b0}};
            recAc <= 32'h00000000;
            recPc <= 32'h00000000;
            returnStatus <= 3'h0;
            previousFrameLink <= {ADDR_W{1'b0}};
            retValid <= 1'b0;
            depth <= 5'h00;
        end else if (clkEn) begin
            callValid <= 1'b0;
            retValid <= 1'b0;
            if (initLoad) begin
                tablePtr <= initTablePtr;
                stackBase <= initStackBase;
                stackTop <= initStackBase;
            end else if (retReq && depth != 5'h00) begin
                curPriority <= savedPc[`IPP_PC_PRI_LSB +: 5];
                traceEnable <= savedPc[`IPP_PC_TRACE_BIT];
                supervisorMode <= savedPc[`IPP_PC_MODE_BIT];
                previousFrameLink <= fpStack[depth - 5'h01];
                stackTop <= stackTop - `IPP_FRAME_BYTES;
                inInterrupt <= (depth != 5'h01);
                depth <= depth - 5'h01;
                retValid <= 1'b1;
                if (reqUsable) begin
                    pendPri[reqPri] <= 1'b1;
                    pendVec[reqVec] <= 1'b1;
                end
            end else begin
                if (doService && !depthFull) begin
                    callValid <= 1'b1;
                    callVector <= svcVec;
                    entryAddr <= tablePtr + `IPP_VEC_ENTRY_OFS +
                        {{(ADDR_W-10){1'b0}}, svcVec, 2'b00};
                    newFramePointer <= nextFrame;
                    recAcAddr <= nextFrame - `IPP_REC_AC_OFS;
                    recPcAddr <= nextFrame - `IPP_REC_PC_OFS;
                    recVecAddr <= nextFrame - `IPP_REC_VEC_OFS;
                    recAc <= curAc;
                    recPc <= curPc;
                    fpStack[depth] <= curFp;
                    depth <= depth + 5'h01;
                    stackTop <= nextFrame;
                    curPriority <= svcVec[7:`IPP_PRI_SHIFT];
                    inInterrupt <= 1'b1;
                    supervisorMode <= 1'b1;
                    traceEnable <= 1'b0;
                    returnStatus <= `IPP_RET_INTERRUPT;
                end
                if (svcFromPend && !depthFull) begin
                    pendVec[svcVec] <= 1'b0;
                    if (levelEmpties) begin
                        pendPri[topPri] <= 1'b0;
                    end
                end
                if (reqUsable && (!reqNow || depthFull)) begin
                    pendPri[reqPri] <= 1'b1;
                    pendVec[reqVec] <= 1'b1;
                end
            end
        end
    end

endmodule // ipp_interrupt_priority_posting

// >>> tb/ipp_table_mem.sv
// table memory model answering vector entry reads
`timescale 1ns/1ps
module ipp_table_mem #(
    parameter [31:0] TABLE_BASE = 32'h00001000
) (
    input wire [31:0] entryAddr, // entry byte address
    output wire [31:0] handlerWord // entry word
);
    reg [31:0] mem [0:264];
    wire [31:0] idx = (entryAddr - TABLE_BASE) >> 2;
    integer k;
    initial begin
        for (k = 0; k < 265; k = k + 1) begin
            mem[k] = 32'h40000003 + (k << 8);
        end
    end
    // outside the table the word is not the last one seen
    assign handlerWord = (idx < 265) ? mem[idx] : 32'hFFFFFFFF;
endmodule // ipp_table_mem

// >>> tb/ipp_checker.sv
// assertion checker for the interrupt priority and posting block
`timescale 1ns/1ps
module ipp_checker (
    input wire sysClk, // clock
    input wire reset, // sync reset
    input wire clkEn, // run enable
    input wire initLoad, // init pulse
    input wire nmiPinN, // nonmaskable pin
    input wire timerReq, // timer pulse
    input wire [7:0] timerVector, // timer vector
    input wire retReq, // return pulse
    input wire [31:0] savedPc, // saved controls
    input wire [4:0] curPriority, // priority
    input wire inInterrupt, // interrupted
    input wire supervisorMode, // mode
    input wire traceEnable, // trace
    input wire [31:0] pendPri, // level bitmap
    input wire [255:0] pendVec, // vector bitmap
    input wire callValid, // call pulse
    input wire [7:0] callVector, // call vector
    input wire [31:0] entryAddr, // entry address
    input wire [31:0] tablePtr, // table base
    input wire [31:0] newFramePointer, // new frame
    input wire [31:0] recAcAddr, // record slot
    input wire [31:0] recPcAddr, // record slot
    input wire [2:0] returnStatus, // return status
    input wire retValid, // return pulse
    input wire [31:0] handlerWord, // entry word
    input wire [31:0] handlerAddr // branch target
);
    wire [4:0] savedPri = savedPc[20:16];
    wire [4:0] tmrPri = timerVector[7:3];
    default clocking cb @(posedge sysClk); endclocking
    default disable iff (reset);
    pri_vec_a: assert property (
        callValid |-> curPriority == callVector[7:3]) else $error("call priority wrong");
    vec_legal_a: assert property (
        callValid |-> callVector >= 8'h08) else $error("unusable vector called");
    call_mode_a: assert property (
        callValid |-> supervisorMode && !traceEnable && returnStatus == 3'h7)
        else $error("call state wrong");
    rec_addr_a: assert property (
        callValid |-> recAcAddr == newFramePointer - 12 && recPcAddr == newFramePointer - 16)
        else $error("record slots wrong");
    entry_addr_a: assert property (
        callValid |-> entryAddr == tablePtr + 36 + {callVector, 2'b00})
        else $error("entry address wrong");
    handler_align_a: assert property (
        handlerAddr == {handlerWord[31:2], 2'b00}) else $error("target not aligned");
    post_sets_a: assert property (
        timerReq && clkEn && !initLoad && !retReq && timerVector >= 8'h08
        && (tmrPri < curPriority || tmrPri == curPriority && curPriority != 5'h1F)
        |=> pendPri[$past(tmrPri)] && pendVec[$past(timerVector)]) else $error("post lost");
    ret_pri_a: assert property (
        retReq && clkEn && inInterrupt && !initLoad
        |=> retValid && curPriority == $past(savedPri)) else $error("return wrong");
    nmi_vec_a: assert property (
        $fell(nmiPinN) |-> ##[1:8] (callValid && callVector == 8'hF8))
        else $error("nonmaskable call missing");
endmodule // ipp_checker
bind ipp_interrupt_priority_posting ipp_checker chk (.sysClk(sysClk), .reset(reset),
    .clkEn(clkEn), .initLoad(initLoad), .nmiPinN(nmiPinN), .timerReq(timerReq),
    .timerVector(timerVector), .retReq(retReq), .savedPc(savedPc),
    .curPriority(curPriority), .inInterrupt(inInterrupt), .supervisorMode(supervisorMode),
    .traceEnable(traceEnable), .pendPri(pendPri), .pendVec(pendVec),
    .callValid(callValid), .callVector(callVector), .entryAddr(entryAddr),
    .tablePtr(tablePtr), .newFramePointer(newFramePointer), .recAcAddr(recAcAddr),
    .recPcAddr(recPcAddr), .returnStatus(returnStatus), .retValid(retValid),
    .handlerWord(handlerWord), .handlerAddr(handlerAddr));

// >>> tb/ipp_interrupt_priority_posting_tb.sv
// self-checking bench for the interrupt priority and posting block
`timescale 1ns/1ps
module ipp_interrupt_priority_posting_tb;
    reg sysClk = 0, reset = 1, clkEn = 1, initLoad = 0, nmiPinN = 1;
    reg timerReq = 0, swReq = 0, retReq = 0;
    reg [7:0] timerVector = 0, swVector = 0;
    reg [31:0] initTablePtr = 0, initStackBase = 0, curAc = 0, curPc = 0, savedPc = 0;
    wire [31:0] tablePtr, stackBase, newFramePointer, entryAddr, recAcAddr, recAc, recPc;
    wire [31:0] pendPri, handlerWord, handlerAddr, recPcAddr, recVecAddr, prevLink;
    wire [255:0] pendVec;
    wire [7:0] callVector;
    wire [4:0] curPriority;
    wire [2:0] returnStatus;
    wire inInterrupt, supervisorMode, traceEnable, callValid, retValid;
    int n_errors = 0, cmp_count = 0, cur = 0, r, i;
    int pend[$];
    int fps[$];
    ipp_interrupt_priority_posting dut (.sysClk(sysClk), .reset(reset), .clkEn(clkEn),
        .initLoad(initLoad), .initTablePtr(initTablePtr), .initStackBase(initStackBase),
        .extReqPin(8'h00), .extVector(8'h00), .nmiPinN(nmiPinN), .timerReq(timerReq),
        .timerVector(timerVector), .swReq(swReq), .swVector(swVector), .curAc(curAc),
        .curPc(curPc), .curFp(curAc), .retReq(retReq), .savedAc(curPc), .savedPc(savedPc),
        .tablePtr(tablePtr), .stackBase(stackBase), .curPriority(curPriority),
        .inInterrupt(inInterrupt), .supervisorMode(supervisorMode), .traceEnable(traceEnable),
        .pendPri(pendPri), .pendVec(pendVec), .callValid(callValid), .callVector(callVector),
        .entryAddr(entryAddr), .newFramePointer(newFramePointer), .recAcAddr(recAcAddr),
        .recPcAddr(recPcAddr), .recVecAddr(recVecAddr), .recAc(recAc), .recPc(recPc),
        .returnStatus(returnStatus), .previousFrameLink(prevLink), .retValid(retValid),
        .handlerWord(handlerWord), .handlerAddr(handlerAddr));
    ipp_table_mem mem (.entryAddr(entryAddr), .handlerWord(handlerWord));
    initial forever #2.5 sysClk = ~sysClk;
    // ****************************************
    // tasks
    // ****************************************
    task end_of_test;
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task wait_call;
        for (i = 0; i < 8; i++) begin
            @(posedge sysClk);
            #1;
            if (callValid === 1'b1) break;
        end
        if (callValid !== 1'b1) begin
            n_errors++;
            $display("Error %0t: no call seen", $time);
            end_of_test;
        end
    endtask
    task req(input logic [7:0] v, input bit tmr);
        int p;
        p = v >> 3;
        @(posedge sysClk);
        swReq <= !tmr;
        timerReq <= tmr;
        swVector <= v;
        timerVector <= v;
        curAc <= $urandom;
        curPc <= $urandom;
        @(posedge sysClk);
        swReq <= 0;
        timerReq <= 0;
        #1;
        if (v < 8) chk(callValid | pendVec[v], 0);
        else if (p > cur || (p == 31 && cur == 31)) begin
            chk(callValid, 1);
            chk(callVector, v);
            chk(curPriority, p);
            chk({supervisorMode, traceEnable, returnStatus}, 5'b10111);
            chk(entryAddr, 32'h1024 + 4 * v);
            chk(handlerAddr, 32'h40000000 + ((9 + v) << 8));
            chk(recAcAddr, newFramePointer - 12);
            chk(recPcAddr, newFramePointer - 16);
            chk(recVecAddr, newFramePointer - 8);
            chk(inInterrupt, 1);
            fps.push_back(curAc);
            chk({recAc, recPc}, {curAc, curPc});
            cur = p;
        end else begin
            chk({pendPri[p], pendVec[v]}, 2'b11);
            pend.push_back(v);
        end
    endtask
    task ret(input int sp);
        int best, k, b;
        @(posedge sysClk);
        retReq <= 1;
        savedPc <= sp << 16;
        @(posedge sysClk);
        retReq <= 0;
        #1;
        chk({retValid, curPriority}, {1'b1, sp[4:0]});
        chk(prevLink, fps.pop_back());
        chk(inInterrupt, fps.size() != 0);
        cur = sp;
        best = -1;
        foreach (pend[j]) if ((pend[j] >> 3) > cur && pend[j] > best) begin
            best = pend[j];
            k = j;
        end
        if (best >= 0) begin
            wait_call;
            chk(callVector, best);
            fps.push_back(curAc);
            pend.delete(k);
            cur = best >> 3;
            b = 0;
            foreach (pend[j]) if ((pend[j] >> 3) == cur) b = 1;
            @(posedge sysClk);
            #1;
            chk({pendVec[best], pendPri[cur]}, b);
        end
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        r = $urandom(32'h6e95d27e);
        repeat (20) @(posedge sysClk);
        reset <= 0;
        @(posedge sysClk);
        initLoad <= 1;
        initTablePtr <= 32'h00001000;
        initStackBase <= 32'h00002000;
        @(posedge sysClk);
        initLoad <= 0;
        #1;
        chk({tablePtr, stackBase}, {32'h00001000, 32'h00002000});
        $display("init test done");
        req(8'h50 | $urandom_range(7), 0);
        chk(newFramePointer, 32'h00002040);
        req(8'h50, 1);
        req(8'h48 | $urandom_range(6), 0);
        req(8'h4F, 1);
        req(8'h03, 0);
        $display("posting test done");
        repeat (3) ret(0);
        $display("dispatch test done");
        req(8'hFF, 0);
        req(8'hFC, 1);
        @(posedge sysClk);
        nmiPinN <= 0;
        wait_call;
        chk(callVector, 8'hF8);
        @(posedge sysClk);
        nmiPinN <= 1;
        $display("top level test done");
        end_of_test;
    end
    initial begin
        #100000;
        n_errors++;
        $display("Error %0t: run too long", $time);
        end_of_test;
    end
endmodule // ipp_interrupt_priority_posting_tb
